// [common/rsc_consts.svh]
/*
 Timing counts, field positions and reset values for the reset source controller.
 Assumes a 25 MHz system clock.
*/
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH
`define RSC_CLK_HZ 25000000
`define RSC_CLK_NS 40
`define RSC_EXT_DELAY_MS 100
`define RSC_EXT_DELAY_CYC ((`RSC_EXT_DELAY_MS * (`RSC_CLK_HZ / 1000)))
`define RSC_UV_FILTER_NS 1000
`define RSC_UV_FILTER_CYC ((`RSC_UV_FILTER_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_SST_LONG 1024
`define RSC_SST_SHORT 2
`define RSC_OFF_STATUS 12'h000
`define RSC_OFF_CAUSE 12'h004
`define RSC_OFF_CONFIG 12'h008
`define RSC_CFG_UV_EN 0
`define RSC_CFG_SST_SHORT 1
`define RSC_CFG_THR_LSB 2
`define RSC_ST_WDT_FLAG 0
`define RSC_ST_PD_FLAG 1
`define RSC_CFG_RESET 32'h0000_0001
`define RSC_TMRC_RESET 8'h08
`define RSC_PORT_RESET 8'hFF
`define RSC_SP_TOP 2'h3
`endif

// [common/rsc_pkg.sv]
/*
 Types for the reset source controller.
 Assumes rsc_consts.svh for numeric values.
*/
package rsc_pkg;
   typedef enum logic [1:0] {
      RSC_RUN = 2'b00,
      RSC_HOLD = 2'b01,
      RSC_EXTEND = 2'b10,
      RSC_WAKE = 2'b11
   } rsc_state_t;
   typedef enum logic [1:0] {
      RSC_CLK_INT_RC = 2'b00,
      RSC_CLK_EXT_RC = 2'b01,
      RSC_CLK_FAST_XTAL = 2'b10,
      RSC_CLK_SLOW_XTAL = 2'b11
   } rsc_clk_src_t;
   typedef struct packed {
      logic core_reset;
      logic pc_sp_clear;
      logic full_init;
      logic por_init;
   } rsc_ctl_t;
endpackage : rsc_pkg

// [design/rsc_reset_ctrl.sv]
/*
 Reset source controller: merges power-on, pin, undervoltage and watchdog
 resets, keeps the expiry and power-down flags, and times start-up waits.
 Assumes presetn is the power-on reset and the reset pin, supply monitor and
 watchdog expiry arrive asynchronously; registers are reached over APB.
*/
// Contract
// - Undervoltage reset enabled and threshold set by configuration.
// - Short low-supply episodes below filter time ignored.
// - Pin or undervoltage reset leaves flags unchanged.
// - Running watchdog expiry: full reset, sets expiry flag.
// - Sleep watchdog expiry sets both flags, clears PC/SP.
// - Flags in status; power-on reset clears both.
// - Wake wait 1024 or 2 for RC, 1024 crystal.
// - Hold execution for extension delay after reset.
// - Power-on reset disables all interrupts.
// - Watchdog counter cleared on reset, restarts counting; sleep watchdog expiry does not clear it.
// - Power-on reset stops timer, clears prescaler.
// - Power-on ports input, stack pointer at top.
// - Every reset clears program counter low byte.
// - Sleep watchdog expiry preserves control registers.
// - Pin low restarts program from address zero.
`timescale 1ns/1ps
`include "rsc_consts.svh"
module rsc_reset_ctrl #(
   parameter int EXT_DELAY_CYC = `RSC_EXT_DELAY_CYC,
   parameter int UV_FILTER_CYC = `RSC_UV_FILTER_CYC,
   parameter int THR_W = 2
) (
   // Clock and power-on reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reset sources
   input wire logic external_reset_pin_n,
   input wire logic supply_low,
   input wire logic watchdog_expiry,
   input wire logic sleep_mode,
   input wire rsc_pkg::rsc_clk_src_t clk_source,
   // Reset controls to the core
   output rsc_pkg::rsc_ctl_t ctl,
   output logic [7:0] program_counter_low,
   output logic [1:0] stack_ptr,
   output logic int_enable,
   output logic [7:0] timer_ctrl,
   output logic [7:0] prescaler,
   output logic [7:0] port_dir,
   output logic watchdog_clear,
   output logic [THR_W-1:0] undervoltage_threshold
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 3'h1;
         sync2_reg <= 3'h1;
      end else begin
         sync1_reg <= {watchdog_expiry, supply_low, external_reset_pin_n};
         sync2_reg <= sync1_reg;
      end
   end
   wire pin_low = ~sync2_reg[0];
   wire sup_low = sync2_reg[1];
   wire wdt_exp = sync2_reg[2];
   // ------------------------------------------------------------
   // Configuration and APB
   // ------------------------------------------------------------
   logic [31:0] cfg_reg;
   logic wdt_flag_reg;
   logic pd_flag_reg;
   logic [1:0] cause_reg;
   wire apb_acc = psel && penable;
   wire apb_wr = apb_acc && pwrite;
   wire cfg_uv_en = cfg_reg[`RSC_CFG_UV_EN];
   wire cfg_sst_short = cfg_reg[`RSC_CFG_SST_SHORT];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= `RSC_CFG_RESET;
      end else if (apb_wr && paddr == `RSC_OFF_CONFIG) begin
         cfg_reg <= {{(30-THR_W){1'b0}}, pwdata[`RSC_CFG_THR_LSB+THR_W-1:0]};
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         undervoltage_threshold <= '0;
      end else begin
         undervoltage_threshold <= cfg_reg[`RSC_CFG_THR_LSB+THR_W-1:`RSC_CFG_THR_LSB];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && !penable) begin
            unique case (paddr)
               `RSC_OFF_STATUS: prdata <= {30'h0, pd_flag_reg, wdt_flag_reg};
               `RSC_OFF_CAUSE: prdata <= {30'h0, cause_reg};
               `RSC_OFF_CONFIG: prdata <= cfg_reg;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end
   // ------------------------------------------------------------
   // Undervoltage filter
   // ------------------------------------------------------------
   logic [31:0] uv_cnt_reg;
   logic uv_trip_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uv_cnt_reg <= 32'h0;
         uv_trip_reg <= 1'b0;
      end else if (!sup_low || !cfg_uv_en) begin
         uv_cnt_reg <= 32'h0;
         uv_trip_reg <= 1'b0;
      end else if (uv_cnt_reg >= 32'(UV_FILTER_CYC)) begin
         uv_trip_reg <= 1'b1;
      end else begin
         uv_cnt_reg <= uv_cnt_reg + 32'h1;
      end
   end
   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   rsc_pkg::rsc_state_t state_reg;
   logic [31:0] cnt_reg;
   logic por_pending_reg;
   wire hard_src = pin_low || uv_trip_reg;
   wire wdt_run = wdt_exp && !sleep_mode;
   wire wdt_sleep = wdt_exp && sleep_mode;
   wire rc_clk = clk_source == rsc_pkg::RSC_CLK_INT_RC || clk_source == rsc_pkg::RSC_CLK_EXT_RC;
   wire [31:0] sst_len = (rc_clk && cfg_sst_short) ? 32'(`RSC_SST_SHORT) : 32'(`RSC_SST_LONG);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= rsc_pkg::RSC_EXTEND;
         cnt_reg <= 32'h0;
      end else begin
         unique case (state_reg)
            rsc_pkg::RSC_RUN: begin
               cnt_reg <= 32'h0;
               if (hard_src || wdt_run) begin
                  state_reg <= rsc_pkg::RSC_HOLD;
               end else if (wdt_sleep) begin
                  state_reg <= rsc_pkg::RSC_WAKE;
               end
            end
            rsc_pkg::RSC_HOLD: begin
               cnt_reg <= 32'h0;
               if (!hard_src && !wdt_exp) begin
                  state_reg <= rsc_pkg::RSC_EXTEND;
               end
            end
            rsc_pkg::RSC_EXTEND: begin
               if (hard_src) begin
                  state_reg <= rsc_pkg::RSC_HOLD;
               end else if (cnt_reg >= 32'(EXT_DELAY_CYC - 1)) begin
                  state_reg <= rsc_pkg::RSC_RUN;
               end else begin
                  cnt_reg <= cnt_reg + 32'h1;
               end
            end
            rsc_pkg::RSC_WAKE: begin
               if (hard_src) begin
                  state_reg <= rsc_pkg::RSC_HOLD;
               end else if (cnt_reg >= sst_len - 32'h1) begin
                  state_reg <= rsc_pkg::RSC_RUN;
               end else begin
                  cnt_reg <= cnt_reg + 32'h1;
               end
            end
         endcase
      end
   end
   // ------------------------------------------------------------
   // Reset flags, recorded on entry to reset
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_flag_reg <= 1'b0;
         pd_flag_reg <= 1'b0;
         cause_reg <= 2'h0;
      end else if (state_reg == rsc_pkg::RSC_RUN) begin
         if (hard_src) begin
            cause_reg <= 2'h1;
         end else if (wdt_run) begin
            wdt_flag_reg <= 1'b1;
            cause_reg <= 2'h2;
         end else if (wdt_sleep) begin
            wdt_flag_reg <= 1'b1;
            pd_flag_reg <= 1'b1;
            cause_reg <= 2'h3;
         end
      end
   end
   // ------------------------------------------------------------
   // Reset controls and initial state outputs
   // ------------------------------------------------------------
   wire in_full = state_reg == rsc_pkg::RSC_HOLD || state_reg == rsc_pkg::RSC_EXTEND;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_pending_reg <= 1'b1;
      end else if (state_reg == rsc_pkg::RSC_RUN) begin
         por_pending_reg <= 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl <= '{core_reset: 1'b1, pc_sp_clear: 1'b1, full_init: 1'b1, por_init: 1'b1};
      end else begin
         ctl.core_reset <= state_reg != rsc_pkg::RSC_RUN;
         ctl.pc_sp_clear <= state_reg != rsc_pkg::RSC_RUN;
         ctl.full_init <= in_full;
         ctl.por_init <= por_pending_reg && in_full;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_counter_low <= 8'h00;
         stack_ptr <= `RSC_SP_TOP;
         watchdog_clear <= 1'b1;
      end else begin
         watchdog_clear <= in_full;
         if (state_reg != rsc_pkg::RSC_RUN) begin
            program_counter_low <= 8'h00;
            stack_ptr <= `RSC_SP_TOP;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_enable <= 1'b0;
         timer_ctrl <= `RSC_TMRC_RESET;
         prescaler <= 8'h00;
         port_dir <= `RSC_PORT_RESET;
      end else if (in_full) begin
         int_enable <= 1'b0;
         timer_ctrl <= `RSC_TMRC_RESET;
         prescaler <= 8'h00;
         port_dir <= `RSC_PORT_RESET;
      end
   end
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_flag_pd;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == rsc_pkg::RSC_RUN && wdt_sleep && !hard_src) |=> wdt_flag_reg && pd_flag_reg;
   endproperty
   a_flag_pd: assert property (p_flag_pd) else $error("sleep expiry flags not set");
   property p_wdt_run;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == rsc_pkg::RSC_RUN && wdt_run && !hard_src) |=> wdt_flag_reg && $stable(pd_flag_reg);
   endproperty
   a_wdt_run: assert property (p_wdt_run) else $error("run expiry flag wrong");
   property p_pin_flags;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == rsc_pkg::RSC_RUN && hard_src) |=> $stable(wdt_flag_reg) && $stable(pd_flag_reg);
   endproperty
   a_pin_flags: assert property (p_pin_flags) else $error("pin reset changed flags");
   property p_uv_off;
      @(posedge pclk) disable iff (!presetn)
      !cfg_uv_en |=> !uv_trip_reg;
   endproperty
   a_uv_off: assert property (p_uv_off) else $error("undervoltage trip while disabled");
   property p_uv_restart;
      @(posedge pclk) disable iff (!presetn)
      !sup_low |=> uv_cnt_reg == 32'h0 && !uv_trip_reg;
   endproperty
   a_uv_restart: assert property (p_uv_restart) else $error("filter not restarted");
   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == rsc_pkg::RSC_HOLD) |=> ctl.core_reset && program_counter_low == 8'h00;
   endproperty
   a_hold: assert property (p_hold) else $error("reset not held");
   property p_wake_len;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == rsc_pkg::RSC_WAKE && cnt_reg == 32'h0 && !hard_src && sst_len == 32'h2)
         |=> state_reg == rsc_pkg::RSC_WAKE ##1 state_reg == rsc_pkg::RSC_RUN;
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("short wake wait wrong");
   property p_sleep_keep;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == rsc_pkg::RSC_WAKE) |=> $stable(port_dir) && $stable(int_enable);
   endproperty
   a_sleep_keep: assert property (p_sleep_keep) else $error("sleep expiry changed state");
   property p_int_off;
      @(posedge pclk) disable iff (!presetn)
      in_full |=> !int_enable && port_dir == `RSC_PORT_RESET && prescaler == 8'h00;
   endproperty
   a_int_off: assert property (p_int_off) else $error("init state not applied");
endmodule : rsc_reset_ctrl

// [verification/rsc_source_model.sv]
/*
 Far-side model: reset pin, supply monitor and watchdog expiry line.
 Assumes commands change right after rising edges of pclk.
*/
`timescale 1ns/1ps
module rsc_source_model (
   // Clock and command
   input wire logic pclk,
   input wire logic start,
   input wire logic [1:0] kind,
   input wire logic [15:0] len,
   // Source lines
   output logic external_reset_pin_n,
   output logic supply_low,
   output logic watchdog_expiry
);
   logic [15:0] left;
   logic [1:0] k;
   initial begin
      left = 16'h0000;
      k = 2'h0;
   end
   // One source is driven for len cycles, then returns to its idle level.
   always @(posedge pclk) begin
      if (start) begin
         left <= len;
         k <= kind;
      end else if (left != 16'h0000) begin
         left <= left - 16'h0001;
      end
   end
   assign external_reset_pin_n = !(left != 16'h0000 && k == 2'h0);
   assign supply_low = left != 16'h0000 && k == 2'h1;
   assign watchdog_expiry = left != 16'h0000 && k == 2'h2;
endmodule : rsc_source_model

// [verification/test_rsc_reset_ctrl.sv]
/*
 Self-checking bench for the reset source controller with a flag model.
 Assumes rsc_pkg, rsc_consts.svh and the source model are compiled first.
*/
`timescale 1ns/1ps
`include "rsc_consts.svh"
module test_rsc_reset_ctrl;
   localparam int EXT = 20;
   localparam int UVF = 8;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_mode, start, err;
   logic external_reset_pin_n, supply_low, watchdog_expiry, int_enable, watchdog_clear;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] kind, stack_ptr, undervoltage_threshold, thr;
   logic [15:0] len;
   logic [7:0] program_counter_low, timer_ctrl, prescaler, port_dir;
   rsc_pkg::rsc_clk_src_t clk_source;
   rsc_pkg::rsc_ctl_t ctl;
   int n_fail, total_checks, n_rst, n_wake, n_full, n_wclr, wd, pd, a, b, c, w0, f0, ex;
   int n_por, p0;

   rsc_reset_ctrl #(.EXT_DELAY_CYC(EXT), .UV_FILTER_CYC(UVF)) dut (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .external_reset_pin_n,
      .supply_low, .watchdog_expiry, .sleep_mode, .clk_source, .ctl, .program_counter_low,
      .stack_ptr, .int_enable, .timer_ctrl, .prescaler, .port_dir, .watchdog_clear,
      .undervoltage_threshold);
   rsc_source_model far (.pclk, .start, .kind, .len, .external_reset_pin_n, .supply_low,
      .watchdog_expiry);

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // Cycle counters of the merged reset, wake clear, full init and watchdog clear.
   always @(posedge pclk) begin
      if (ctl.core_reset === 1'b1) n_rst++;
      if (ctl.pc_sp_clear === 1'b1) n_wake++;
      if (ctl.full_init === 1'b1) n_full++;
      if (watchdog_clear === 1'b1) n_wclr++;
      if (ctl.por_init === 1'b1) n_por++;
   end

   task complete_run;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   task fail(input string m);
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
   endtask : fail
   task chk(input logic [39:0] got, input logic [39:0] exp, input string m);
      total_checks++;
      if (got !== exp) fail(m);
   endtask : chk
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         fail("no ready");
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rdchk(input logic [11:0] ad, input logic [31:0] mask, input logic [31:0] exp);
      apb(1'b0, ad, 32'h0000_0000);
      chk(rd & mask, exp, "read data");
   endtask : rdchk
   task src(input logic [1:0] k, input int n);
      @(posedge pclk);
      kind <= k;
      len <= n[15:0];
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      repeat (n) @(posedge pclk);
   endtask : src
   task wait_idle(input int base);
      int i;
      for (i = 0; i < 1500; i++) begin
         @(negedge pclk);
         if (n_rst > base && ctl.core_reset === 1'b0) break;
      end
      if (i == 1500) begin
         fail("reset wait");
         complete_run();
      end
   endtask : wait_idle
   task ev(input logic [1:0] k, input int n, input logic [31:0] cause);
      b = n_rst;
      c = n_wclr;
      w0 = n_wake;
      f0 = n_full;
      p0 = n_por;
      src(k, n);
      wait_idle(b);
      chk(n_por == p0, 1'b1, "power-on init outside power-on");
      chk({program_counter_low, stack_ptr, int_enable, timer_ctrl, prescaler, port_dir},
         {8'h00, `RSC_SP_TOP, 1'b0, `RSC_TMRC_RESET, 8'h00, `RSC_PORT_RESET}, "init");
      rdchk(`RSC_OFF_STATUS, 32'h3, 32'(pd * 2 + wd));
      rdchk(`RSC_OFF_CAUSE, 32'h3, cause);
   endtask : ev
   task full_chk;
      chk(n_rst - b >= EXT, 1'b1, "extension");
      chk(n_wclr > c, 1'b1, "watchdog clear");
   endtask : full_chk

   initial begin
      void'($urandom(41814));
      {presetn, psel, penable, pwrite, sleep_mode, start, kind, len} = '0;
      {paddr, pwdata, wd, pd} = '0;
      clk_source = rsc_pkg::RSC_CLK_INT_RC;
      repeat (8) @(posedge pclk);
      chk({program_counter_low, stack_ptr, int_enable, timer_ctrl, prescaler, port_dir},
         {8'h00, `RSC_SP_TOP, 1'b0, `RSC_TMRC_RESET, 8'h00, `RSC_PORT_RESET}, "por");
      b = n_rst;
      c = n_wclr;
      p0 = n_por;
      presetn <= 1'b1;
      wait_idle(b);
      full_chk();
      chk(n_por - p0 >= EXT, 1'b1, "power-on init");
      rdchk(`RSC_OFF_STATUS, 32'h3, 32'h0);
      rdchk(`RSC_OFF_CONFIG, 32'hF, 32'h1);
      ev(2'h0, 5, 32'h1);
      full_chk();
      wd = 1;
      ev(2'h2, 1, 32'h2);
      full_chk();
      ev(2'h0, 3, 32'h1);
      b = n_rst;
      src(2'h1, 1 + $urandom % (UVF - 4));
      repeat (12) @(negedge pclk);
      chk(n_rst == b, 1'b1, "short dip");
      ev(2'h1, UVF + 6, 32'h1);
      full_chk();
      thr = 2'($urandom);
      apb(1'b1, `RSC_OFF_CONFIG, {28'h0, thr, 2'b10});
      rdchk(`RSC_OFF_CONFIG, 32'hF, {28'h0, thr, 2'b10});
      chk(undervoltage_threshold, thr, "threshold");
      b = n_rst;
      src(2'h1, UVF + 6);
      repeat (12) @(negedge pclk);
      chk(n_rst == b, 1'b1, "uv disabled");
      apb(1'b1, `RSC_OFF_CONFIG, {28'h0, thr, 2'b11});
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk(err, 1'b1, "unmapped");
      apb(1'b1, `RSC_OFF_STATUS, 32'h0000_0000);
      rdchk(`RSC_OFF_STATUS, 32'h3, 32'h1);
      sleep_mode <= 1'b1;
      for (a = 0; a < 4; a++) begin
         clk_source <= rsc_pkg::rsc_clk_src_t'(a);
         pd = 1;
         ex = (a < 2) ? `RSC_SST_SHORT : `RSC_SST_LONG;
         ev(2'h2, 1, 32'h3);
         chk(n_wake - w0 >= ex && n_wake - w0 <= ex + 3, 1'b1, "wake wait");
         chk(n_full == f0, 1'b1, "sleep keeps state");
      end
      sleep_mode <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      wd = 0;
      pd = 0;
      b = n_rst;
      p0 = n_por;
      wait_idle(b);
      chk(n_por - p0 >= EXT, 1'b1, "power-on init again");
      rdchk(`RSC_OFF_STATUS, 32'h3, 32'h0);
      complete_run();
   end
endmodule : test_rsc_reset_ctrl
